/* shared/route_pkg.sv */
package route_pkg;

  // Sample and index widths
  localparam int SW        = 32;
  localparam int NDEST     = 8;
  localparam int NSRC      = 19;
  localparam int NSTAGE    = 2;
  localparam int NCOEF     = 5;
  localparam int COEF_FRAC = 14;

  // Register byte offsets
  localparam logic [7:0] OFF_MAP0     = 8'h00;  // Dest 0..7 route+shift, 4 bytes apart
  localparam logic [7:0] OFF_MIC      = 8'h20;  // Mic shift and saturate enable
  localparam logic [7:0] OFF_FORMAT   = 8'h24;  // Interface formats, locked after start
  localparam logic [7:0] OFF_ALGO     = 8'h28;  // Algorithm enables
  localparam logic [7:0] OFF_STATUS   = 8'h2C;  // Started, delay estimate done
  localparam logic [7:0] OFF_START    = 8'h30;  // Write 1 locks formats and starts the delay estimator
  localparam logic [7:0] OFF_COEF0    = 8'h40;  // 10 coefficients, 4 bytes apart
  localparam logic [7:0] OFF_COEF_END = 8'h68;

  // Destination indexes
  localparam logic [2:0] DST_USB0 = 3'h0;
  localparam logic [2:0] DST_I2S0 = 3'h2;
  localparam logic [2:0] DST_REF0 = 3'h4;
  localparam logic [2:0] DST_MIC0 = 3'h6;

  // Source indexes
  localparam logic [4:0] SRC_MUTE   = 5'h00;
  localparam logic [4:0] SRC_UAVG   = 5'h01;
  localparam logic [4:0] SRC_UDIF   = 5'h02;
  localparam logic [4:0] SRC_IAVG   = 5'h03;
  localparam logic [4:0] SRC_IDIF   = 5'h04;
  localparam logic [4:0] SRC_POUT0  = 5'h05;
  localparam logic [4:0] SRC_POUT1  = 5'h06;
  localparam logic [4:0] SRC_USB0   = 5'h07;
  localparam logic [4:0] SRC_USB1   = 5'h08;
  localparam logic [4:0] SRC_I2S0   = 5'h09;
  localparam logic [4:0] SRC_I2S1   = 5'h0A;
  localparam logic [4:0] SRC_MIC0   = 5'h0B;
  localparam logic [4:0] SRC_MIC1   = 5'h0C;
  localparam logic [4:0] SRC_PKPIPE = 5'h0D;
  localparam logic [4:0] SRC_PKMIC  = 5'h0E;
  localparam logic [4:0] SRC_PKREF  = 5'h0F;
  localparam logic [4:0] SRC_PKALL  = 5'h10;
  localparam logic [4:0] SRC_PKAUSB = 5'h11;
  localparam logic [4:0] SRC_PKAI2S = 5'h12;

  // Reset values
  localparam logic [4:0]  RST_SRC_USB0 = SRC_POUT0;
  localparam logic [4:0]  RST_SRC_USB1 = SRC_POUT1;
  localparam logic [4:0]  RST_SRC_I2S0 = SRC_POUT0;
  localparam logic [4:0]  RST_SRC_I2S1 = SRC_USB0;
  localparam logic [4:0]  RST_SRC_REF0 = SRC_USB0;
  localparam logic [4:0]  RST_SRC_REF1 = SRC_USB1;
  localparam logic [4:0]  RST_SRC_MIC0 = SRC_MIC0;
  localparam logic [4:0]  RST_SRC_MIC1 = SRC_MIC1;
  localparam logic [3:0]  RST_FORMAT   = 4'h0;   // 48k, 16-bit USB / 32-bit serial
  localparam logic [2:0]  RST_ALGO     = 3'h7;   // Echo, interference, noise enabled
  localparam logic [17:0] RST_COEF_B0  = 18'h04000;  // Unity pass-through
  localparam int          REPEAT_N     = 3;      // 16k to 48k repeats
  localparam logic [5:0]  SHIFT_MAX    = 6'h1F;

  // Per-destination setting
  typedef struct packed {
    logic [4:0]       src;
    logic signed [5:0] shift;
  } dest_cfg_t;

  // One channel pair of samples
  typedef struct packed {
    logic signed [SW-1:0] ch0;
    logic signed [SW-1:0] ch1;
  } pair_t;

endpackage

/* src/biquad_stage.sv */
module biquad_stage (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst,
  // Coefficients b0 b1 b2 a1 a2, Q4.14
  input  wire logic signed [17:0]   coef [5],
  // Sample stream
  input  wire logic                 inStb,
  input  wire logic signed [31:0]   inSample,
  output logic                      outStb,
  output logic signed [31:0]        outSample
);

  logic signed [31:0] x1_reg;
  logic signed [31:0] x2_reg;
  logic signed [31:0] y1_reg;
  logic signed [31:0] y2_reg;
  logic signed [63:0] acc;
  logic signed [31:0] yNext;

  // Direct form I accumulation
  always_comb begin
    acc = 64'(inSample) * 64'(coef[0]) + 64'(x1_reg) * 64'(coef[1])
        + 64'(x2_reg) * 64'(coef[2]) - 64'(y1_reg) * 64'(coef[3])
        - 64'(y2_reg) * 64'(coef[4]);
    yNext = 32'(acc >>> route_pkg::COEF_FRAC);
  end

  // History and output
  always_ff @(posedge mclk) begin
    if (rst) begin
      x1_reg    <= '0;
      x2_reg    <= '0;
      y1_reg    <= '0;
      y2_reg    <= '0;
      outSample <= '0;
      outStb    <= 1'b0;
    end else begin
      outStb <= inStb;
      if (inStb) begin
        x2_reg    <= x1_reg;
        x1_reg    <= inSample;
        y2_reg    <= y1_reg;
        y1_reg    <= yNext;
        outSample <= yNext;
      end
    end
  end

endmodule

/* src/audio_route_scale_filter.sv */
module audio_route_scale_filter (
  // Clock and reset
  input  wire logic                    mclk,
  input  wire logic                    rst,
  // AHB-Lite slave
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic      [31:0]             hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  // 48 kHz frame input: host USB, serial audio
  input  wire logic                    frameStb,
  input  wire route_pkg::pair_t        usbIn,
  input  wire route_pkg::pair_t        i2sIn,
  input  wire logic                    refMono,
  // 16 kHz domain: raw mics, pipeline outputs
  input  wire logic                    micStb,
  input  wire route_pkg::pair_t        micRaw,
  input  wire route_pkg::pair_t        pipeOut,
  // Pipeline inputs
  output route_pkg::pair_t             pipeRef,
  output route_pkg::pair_t             pipeMic,
  // Algorithm control
  output logic                         aecEnable,
  output logic                         icEnable,
  output logic                         nsEnable,
  output logic                         delayEstRun,
  input  wire logic                    delayEstDone,
  // Output stream via two-entry buffer
  output logic                         outValid,
  input  wire logic                    outReady,
  output route_pkg::pair_t             usbOut,
  output route_pkg::pair_t             i2sOut,
  output logic      [3:0]              formatCfg
);

  typedef enum logic [1:0] {IDLE_S, RUN_S, DONE_S} est_t;

  route_pkg::dest_cfg_t  map_reg [8];
  logic [4:0]            micShift_reg;
  logic                  micSat_reg;
  logic [3:0]            format_reg;
  logic [2:0]            algo_reg;
  logic                  started_reg;
  est_t                  est_reg;
  logic signed [17:0]    coef_reg [10];
  logic [1:0]            rep_reg;
  logic [7:0]            aAddr_reg;
  logic                  aWrite_reg;
  logic                  aValid_reg;
  route_pkg::pair_t      micHold_reg;
  route_pkg::pair_t      pipeHold_reg;
  logic [31:0]           routed [8];
  logic signed [31:0]    micGain [2];
  logic                  bufInReady;

  // Shift with saturation on left, arithmetic on right
  function automatic logic signed [31:0] shiftSat(input logic signed [31:0] v,
                                                  input logic signed [5:0] s,
                                                  input logic sat);
    logic signed [63:0] wide;
    logic [5:0]         amt;
    wide = 64'(v);
    amt  = 6'(-s);
    if (s < 0) begin
      shiftSat = v >>> amt;
    end else begin
      wide = wide <<< s;
      if (sat && wide > 64'sh7FFFFFFF) begin
        shiftSat = 32'sh7FFFFFFF;
      end else if (sat && wide < -64'sh80000000) begin
        shiftSat = -32'sh80000000;
      end else begin
        shiftSat = 32'(wide);
      end
    end
  endfunction

  // Half of sum or difference of a pair
  function automatic logic signed [31:0] halfOf(input route_pkg::pair_t p, input logic dif);
    logic signed [32:0] t;
    t = dif ? 33'(p.ch0) - 33'(p.ch1) : 33'(p.ch0) + 33'(p.ch1);
    halfOf = 32'(t >>> 1);
  endfunction

  // AHB address phase capture
  always_ff @(posedge mclk) begin
    if (rst) begin
      aValid_reg <= 1'b0;
      aWrite_reg <= 1'b0;
      aAddr_reg  <= '0;
    end else if (hready) begin
      aValid_reg <= hsel & htrans[1];
      aWrite_reg <= hwrite;
      aAddr_reg  <= haddr[7:0];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  logic wr;
  assign wr = aValid_reg & aWrite_reg;

  // Routing and shift table, live updates allowed
  always_ff @(posedge mclk) begin
    if (rst) begin
      map_reg[0] <= '{route_pkg::RST_SRC_USB0, 6'sh00};
      map_reg[1] <= '{route_pkg::RST_SRC_USB1, 6'sh00};
      map_reg[2] <= '{route_pkg::RST_SRC_I2S0, 6'sh00};
      map_reg[3] <= '{route_pkg::RST_SRC_I2S1, 6'sh00};
      map_reg[4] <= '{route_pkg::RST_SRC_REF0, 6'sh00};
      map_reg[5] <= '{route_pkg::RST_SRC_REF1, 6'sh00};
      map_reg[6] <= '{route_pkg::RST_SRC_MIC0, 6'sh00};
      map_reg[7] <= '{route_pkg::RST_SRC_MIC1, 6'sh00};
    end else if (wr && aAddr_reg < route_pkg::OFF_MIC && hwdata[4:0] < 5'(route_pkg::NSRC)) begin
      map_reg[aAddr_reg[4:2]] <= '{hwdata[4:0], 6'(hwdata[13:8])};
    end
  end

  // Mic gain, algorithms, coefficients
  always_ff @(posedge mclk) begin
    if (rst) begin
      micShift_reg <= '0;
      micSat_reg   <= 1'b0;
      algo_reg     <= route_pkg::RST_ALGO;
      for (int i = 0; i < 10; i++) begin
        coef_reg[i] <= (i % 5 == 0) ? route_pkg::RST_COEF_B0 : 18'h00000;
      end
    end else if (wr) begin
      if (aAddr_reg == route_pkg::OFF_MIC) begin
        micShift_reg <= hwdata[4:0];
        micSat_reg   <= hwdata[15:8] == 8'h01;
      end
      if (aAddr_reg == route_pkg::OFF_ALGO) begin
        algo_reg <= hwdata[2:0];
      end
      if (aAddr_reg >= route_pkg::OFF_COEF0 && aAddr_reg < route_pkg::OFF_COEF_END) begin
        coef_reg[4'((aAddr_reg - route_pkg::OFF_COEF0) >> 2)] <= 18'(hwdata);
      end
    end
  end

  // Formats locked once started
  always_ff @(posedge mclk) begin
    if (rst) begin
      format_reg  <= route_pkg::RST_FORMAT;
      started_reg <= 1'b0;
    end else if (wr) begin
      if (aAddr_reg == route_pkg::OFF_FORMAT && !started_reg) begin
        format_reg <= hwdata[3:0];
      end
      if (aAddr_reg == route_pkg::OFF_START && hwdata[0]) begin
        started_reg <= 1'b1;
      end
    end
  end

  // Delay estimator runs once after start
  always_ff @(posedge mclk) begin
    if (rst) begin
      est_reg <= IDLE_S;
    end else begin
      case (est_reg)
        IDLE_S:  if (started_reg) est_reg <= RUN_S;
        RUN_S:   if (delayEstDone) est_reg <= DONE_S;
        DONE_S:  est_reg <= DONE_S;
        default: est_reg <= IDLE_S;
      endcase
    end
  end

  assign delayEstRun = est_reg == RUN_S;
  assign aecEnable   = algo_reg[0];
  assign icEnable    = algo_reg[1];
  assign nsEnable    = algo_reg[2];
  assign formatCfg   = format_reg;

  // Read data, combinational from the captured address in data phase
  always_comb begin
    hrdata = 32'h00000000;
    if (aValid_reg && !aWrite_reg) begin
      if (aAddr_reg < route_pkg::OFF_MIC) begin
        hrdata = {18'h00000, 6'(map_reg[aAddr_reg[4:2]].shift), 3'h0,
                  map_reg[aAddr_reg[4:2]].src};
      end else if (aAddr_reg == route_pkg::OFF_MIC) begin
        hrdata = {23'h000000, micSat_reg, 3'h0, micShift_reg};
      end else if (aAddr_reg == route_pkg::OFF_FORMAT) begin
        hrdata = {28'h0000000, format_reg};
      end else if (aAddr_reg == route_pkg::OFF_ALGO) begin
        hrdata = {29'h00000000, algo_reg};
      end else if (aAddr_reg == route_pkg::OFF_STATUS) begin
        hrdata = {30'h00000000, est_reg == DONE_S, started_reg};
      end else if (aAddr_reg >= route_pkg::OFF_COEF0 && aAddr_reg < route_pkg::OFF_COEF_END) begin
        hrdata = 32'(coef_reg[4'((aAddr_reg - route_pkg::OFF_COEF0) >> 2)]);
      end
    end
  end

  // Mic gain with optional saturation
  always_comb begin
    micGain[0] = shiftSat(micRaw.ch0, 6'(micShift_reg), micSat_reg);
    micGain[1] = shiftSat(micRaw.ch1, 6'(micShift_reg), micSat_reg);
  end

  // Hold 16 kHz samples; repeat across three 48 kHz frames
  always_ff @(posedge mclk) begin
    if (rst) begin
      micHold_reg  <= '0;
      pipeHold_reg <= '0;
      rep_reg      <= '0;
    end else begin
      if (micStb) begin
        micHold_reg  <= '{micGain[0], micGain[1]};
        pipeHold_reg <= pipeOut;
        rep_reg      <= '0;
      end else if (frameStb && rep_reg != 2'(route_pkg::REPEAT_N - 1)) begin
        rep_reg <= rep_reg + 2'h1;
      end
    end
  end

  // Source selection per destination
  always_comb begin
    route_pkg::pair_t refIn;
    refIn = usbIn;
    if (refMono) begin
      refIn.ch1 = usbIn.ch0;
    end
    for (int d = 0; d < 8; d++) begin
      case (map_reg[d].src)
        route_pkg::SRC_MUTE:   routed[d] = '0;
        route_pkg::SRC_UAVG:   routed[d] = halfOf(refIn, 1'b0);
        route_pkg::SRC_UDIF:   routed[d] = halfOf(refIn, 1'b1);
        route_pkg::SRC_IAVG:   routed[d] = halfOf(i2sIn, 1'b0);
        route_pkg::SRC_IDIF:   routed[d] = halfOf(i2sIn, 1'b1);
        route_pkg::SRC_POUT0:  routed[d] = pipeHold_reg.ch0;
        route_pkg::SRC_POUT1:  routed[d] = pipeHold_reg.ch1;
        route_pkg::SRC_USB0:   routed[d] = refIn.ch0;
        route_pkg::SRC_USB1:   routed[d] = refIn.ch1;
        route_pkg::SRC_I2S0:   routed[d] = i2sIn.ch0;
        route_pkg::SRC_I2S1:   routed[d] = i2sIn.ch1;
        route_pkg::SRC_MIC0:   routed[d] = micHold_reg.ch0;
        route_pkg::SRC_MIC1:   routed[d] = micHold_reg.ch1;
        route_pkg::SRC_PKPIPE: routed[d] = rep_reg[0] ? pipeHold_reg.ch1 : pipeHold_reg.ch0;
        route_pkg::SRC_PKMIC:  routed[d] = rep_reg[0] ? micHold_reg.ch1 : micHold_reg.ch0;
        route_pkg::SRC_PKREF:  routed[d] = rep_reg[0] ? pipeRef.ch1 : pipeRef.ch0;
        route_pkg::SRC_PKALL:  routed[d] = rep_reg == 2'h0 ? micHold_reg.ch0 :
                                           rep_reg == 2'h1 ? pipeRef.ch0 : pipeHold_reg.ch0;
        route_pkg::SRC_PKAUSB: routed[d] = rep_reg[0] ? refIn.ch1 : micHold_reg.ch0;
        route_pkg::SRC_PKAI2S: routed[d] = rep_reg[0] ? i2sIn.ch1 : micHold_reg.ch0;
        default:               routed[d] = '0;
      endcase
    end
  end

  // Pipeline inputs: scaled, mic 0 feed through the filter pair
  logic               s1Stb;
  logic               s2Stb;
  logic signed [31:0] s1Out;
  logic signed [31:0] s2Out;
  logic signed [17:0] c1 [5];
  logic signed [17:0] c2 [5];
  always_comb begin
    for (int k = 0; k < 5; k++) begin
      c1[k] = coef_reg[k];
      c2[k] = coef_reg[k + 5];
    end
  end

  biquad_stage stage1 (
    .mclk      (mclk),
    .rst       (rst),
    .coef      (c1),
    .inStb     (micStb),
    .inSample  (shiftSat(routed[6], map_reg[6].shift, 1'b1)),
    .outStb    (s1Stb),
    .outSample (s1Out)
  );

  biquad_stage stage2 (
    .mclk      (mclk),
    .rst       (rst),
    .coef      (c2),
    .inStb     (s1Stb),
    .inSample  (s1Out),
    .outStb    (s2Stb),
    .outSample (s2Out)
  );

  // Pipeline input registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      pipeRef <= '0;
      pipeMic <= '0;
    end else begin
      if (frameStb) begin
        pipeRef.ch0 <= shiftSat(routed[4], map_reg[4].shift, 1'b1);
        pipeRef.ch1 <= shiftSat(routed[5], map_reg[5].shift, 1'b1);
      end
      if (s2Stb) begin
        pipeMic.ch0 <= s2Out;
      end
      if (micStb) begin
        pipeMic.ch1 <= shiftSat(routed[7], map_reg[7].shift, 1'b1);
      end
    end
  end

  // Output frames into the two-entry buffer
  logic [127:0] bufIn;
  logic [127:0] bufOut;
  always_comb begin
    for (int d = 0; d < 4; d++) begin
      bufIn[127 - 32*d -: 32] = shiftSat(routed[d], map_reg[d].shift, 1'b1);
    end
  end

  // Two-entry buffer
  logic [127:0] buf_reg [2];
  logic [1:0]   cnt_reg;
  logic         rdPtr_reg;
  logic         wrPtr_reg;
  logic         push;
  logic         pop;
  assign bufInReady = cnt_reg != 2'h2;
  assign push       = frameStb & bufInReady;
  assign pop        = outValid & outReady;
  assign outValid   = cnt_reg != 2'h0;
  assign bufOut     = buf_reg[rdPtr_reg];
  assign usbOut     = bufOut[127:64];
  assign i2sOut     = bufOut[63:0];

  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_reg    <= '0;
      rdPtr_reg  <= 1'b0;
      wrPtr_reg  <= 1'b0;
      buf_reg[0] <= '0;
      buf_reg[1] <= '0;
    end else begin
      if (push) begin
        buf_reg[wrPtr_reg] <= bufIn;
        wrPtr_reg          <= ~wrPtr_reg;
      end
      if (pop) begin
        rdPtr_reg <= ~rdPtr_reg;
      end
      cnt_reg <= cnt_reg + 2'(push) - 2'(pop);
    end
  end

endmodule

/* test/audio_route_scale_filter_checker.sv */
module audio_route_scale_filter_checker (
  // Clock and reset
  input wire logic             mclk,
  input wire logic             rst,
  // Register bus
  input wire logic             hsel,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic             hready,
  input wire logic [31:0]      hrdata,
  input wire logic             hreadyout,
  input wire logic             hresp,
  // Sample streams
  input wire logic             frameStb,
  input wire logic             micStb,
  input wire route_pkg::pair_t pipeRef,
  input wire route_pkg::pair_t pipeMic,
  input wire logic             outValid,
  input wire logic             outReady,
  input wire route_pkg::pair_t usbOut,
  input wire route_pkg::pair_t i2sOut,
  // Control levels
  input wire logic [3:0]       formatCfg,
  input wire logic             aecEnable,
  input wire logic             icEnable,
  input wire logic             nsEnable
);
  logic       rdPhase;
  logic       wrPhase;
  logic [1:0] occ;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Data phase flags of the bus
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdPhase <= 1'b0;
      wrPhase <= 1'b0;
    end else begin
      rdPhase <= hsel && hready && htrans[1] && !hwrite;
      wrPhase <= hsel && hready && htrans[1] && hwrite;
    end
  end
  // Words held in the output buffer
  always_ff @(posedge mclk) begin
    if (rst) begin
      occ <= 2'h0;
    end else begin
      occ <= occ + {1'b0, frameStb && occ != 2'h2} - {1'b0, outValid && outReady};
    end
  end
  sequence sPush;
    frameStb && !outValid;
  endsequence
  sequence sStall;
    outValid && !outReady;
  endsequence
  AST_BUS_OKAY:
    assert property (hreadyout && !hresp) else $error("bus wait or error response");
  AST_RDATA_IDLE:
    assert property (!rdPhase |-> hrdata == 32'h0) else $error("read data outside data phase");
  AST_VALID_NEXT:
    assert property (sPush |=> outValid) else $error("frame not offered next cycle");
  AST_OCCUPANCY:
    assert property (outValid == (occ != 2'h0)) else $error("valid disagrees with buffer fill");
  AST_STALL_HOLD:
    assert property (sStall |=> outValid && $stable(usbOut) && $stable(i2sOut))
      else $error("stalled word changed or lost");
  AST_ENABLE_RESET:
    assert property ($fell(rst) |-> aecEnable && icEnable && nsEnable)
      else $error("enables not set after reset");
  AST_FORMAT_WRITE:
    assert property ($changed(formatCfg) && !$past(rst) |-> $past(wrPhase))
      else $error("format moved without a write");
  AST_REF_TIMING:
    assert property ($changed(pipeRef) && !$past(rst) |-> $past(frameStb))
      else $error("reference feed moved without a frame");
  AST_MIC_TIMING:
    assert property ($changed(pipeMic.ch1) && !$past(rst) |-> $past(micStb))
      else $error("mic feed moved without a sample");
endmodule
bind audio_route_scale_filter audio_route_scale_filter_checker chk (
  .mclk(mclk), .rst(rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .frameStb(frameStb),
  .micStb(micStb), .pipeRef(pipeRef), .pipeMic(pipeMic), .outValid(outValid),
  .outReady(outReady), .usbOut(usbOut), .i2sOut(i2sOut), .formatCfg(formatCfg),
  .aecEnable(aecEnable), .icEnable(icEnable), .nsEnable(nsEnable));

/* test/host_sink.sv */
module host_sink (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // Pace set by the bench
  input  wire logic stall,
  input  wire logic slow,
  // Stream handshake
  output logic      outReady
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] paceReg;
  // Ready every cycle, one in three when slow, never when stalled
  always_ff @(posedge mclk) begin
    if (rst) begin
      paceReg  <= 2'h0;
      outReady <= 1'b0;
    end else begin
      paceReg  <= (paceReg == 2'h2) ? 2'h0 : paceReg + 2'h1;
      outReady <= !stall && (!slow || paceReg == 2'h0);
    end
  end
endmodule

/* test/audio_route_scale_filter_tb.sv */
module audio_route_scale_filter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic             mclk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic             frameStb = 1'b0, micStb = 1'b0, stall = 1'b0, slow = 1'b0;
  logic             refMono = 1'b0, estDone = 1'b0;
  logic [31:0]      haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]       htrans = 2'h0;
  logic [2:0]       hsize = 3'h2;
  logic [3:0]       formatCfg;
  logic             hreadyout, hresp, aecEnable, icEnable, nsEnable, delayEstRun;
  logic             outValid, outReady;
  route_pkg::pair_t usbIn = '0, i2sIn = '0, micRaw = '0, u, s, v;
  route_pkg::pair_t pipeRef, pipeMic, usbOut, i2sOut;
  logic [127:0]     expQ [$];
  logic [4:0]       rstSrc [8];
  int               n_fail = 0, comparisons = 0, i;
  // 25 MHz clock
  always #20 mclk = ~mclk;
  audio_route_scale_filter uut (
    .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .frameStb(frameStb), .usbIn(usbIn),
    .i2sIn(i2sIn), .refMono(refMono), .micStb(micStb), .micRaw(micRaw), .pipeOut('0),
    .pipeRef(pipeRef), .pipeMic(pipeMic), .aecEnable(aecEnable), .icEnable(icEnable),
    .nsEnable(nsEnable), .delayEstRun(delayEstRun), .delayEstDone(estDone),
    .outValid(outValid), .outReady(outReady), .usbOut(usbOut), .i2sOut(i2sOut),
    .formatCfg(formatCfg));
  host_sink sink (.mclk(mclk), .rst(rst), .stall(stall), .slow(slow), .outReady(outReady));
  // Verdict and end of run
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Compare and tally
  task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Wait for hready under a bound
  task automatic waitRdy;
    int k;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      n_fail++;
      complete_run();
    end
  endtask
  // One single word transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    waitRdy();
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    waitRdy();
    rd = hrdata;
  endtask
  // Power-of-two gain with saturation on left shifts
  function automatic logic signed [31:0] gain(input logic signed [31:0] x, input int sh);
    logic signed [63:0] w;
    w = x;
    if (sh < 0) return x >>> (-sh);
    w = w <<< sh;
    if (w > 64'sh7FFFFFFF) return 32'sh7FFFFFFF;
    if (w < -64'sh80000000) return 32'sh80000000;
    return w[31:0];
  endfunction
  // Expected output word for the routing set up below
  function automatic logic [127:0] mk(input route_pkg::pair_t a, input route_pkg::pair_t b,
                                      input logic sel);
    return {gain(sel ? a.ch1 : a.ch0, 4), gain((a.ch0 - a.ch1) >>> 1, -1), 32'h0,
            gain(b.ch0, -3)};
  endfunction
  // One frame, noted as expected only when kept
  task automatic frame(input logic [127:0] e, input logic keep);
    @(posedge mclk);
    frameStb <= 1'b1;
    usbIn    <= u;
    i2sIn    <= s;
    if (keep) expQ.push_back(e);
    @(posedge mclk);
    frameStb <= 1'b0;
  endtask
  // Let the sink empty the buffer under a bound
  task automatic drain;
    int k;
    for (k = 0; k < 200 && expQ.size() != 0; k++) @(posedge mclk);
    if (expQ.size() != 0) begin
      n_fail++;
      complete_run();
    end
  endtask
  // Scoreboard for words leaving the buffer
  always @(posedge mclk) begin
    if (!rst && outValid === 1'b1 && outReady === 1'b1) begin
      if (expQ.size() == 0) chk("extra word", 128'h0, {1'b1, usbOut, i2sOut});
      else chk("stream word", expQ.pop_front(), {usbOut, i2sOut});
    end
  end
  initial begin
    rstSrc = '{route_pkg::RST_SRC_USB0, route_pkg::RST_SRC_USB1, route_pkg::RST_SRC_I2S0,
               route_pkg::RST_SRC_I2S1, route_pkg::RST_SRC_REF0, route_pkg::RST_SRC_REF1,
               route_pkg::RST_SRC_MIC0, route_pkg::RST_SRC_MIC1};
    void'($urandom(50));
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    // Reset values and an unmapped read
    for (i = 0; i < 8; i++) begin
      bus(1'b0, 8'(4 * i), 32'h0);
      chk("map reset", 128'(rstSrc[i]), 128'(rd));
    end
    bus(1'b0, route_pkg::OFF_ALGO, 32'h0);
    chk("algo reset", 128'(route_pkg::RST_ALGO), 128'(rd));
    bus(1'b0, route_pkg::OFF_FORMAT, 32'h0);
    chk("format reset", 128'(route_pkg::RST_FORMAT), 128'(rd));
    bus(1'b0, 8'h3C, 32'hFFFFFFFF);
    chk("unmapped", 128'h0, 128'(rd));
    $display("reset values done");
    // Routing and shifts, then a refused source
    bus(1'b1, 8'h00, 32'h00000407);
    bus(1'b1, 8'h04, 32'h00003F02);
    bus(1'b1, 8'h08, 32'h00000000);
    bus(1'b1, 8'h0C, 32'h00003D09);
    bus(1'b1, 8'h00, 32'h00000013);
    bus(1'b0, 8'h00, 32'h0);
    chk("refused source", 128'h407, 128'(rd));
    slow <= 1'b1;
    for (i = 0; i < 6; i++) begin
      u.ch1 = (32'($urandom) & 32'h00FFFFFE) - 32'h00800000;
      u.ch0 = (i == 0) ? 32'h10000000 : (i == 1) ? 32'hF0000000 : u.ch1 + 32'h00001234 * 2;
      s = {32'($urandom), 32'($urandom)};
      // Mono reference on one frame copies channel 0
      v = u;
      if (i == 4) v.ch1 = u.ch0;
      refMono <= (i == 4);
      if (i == 3) bus(1'b1, 8'h00, 32'h00000408);
      frame(mk(v, s, i >= 3), 1'b1);
      #1;
      chk("ref feed", 128'(v), 128'(pipeRef));
      drain();
    end
    $display("routing and gain done");
    // Receiver stalls: two words kept, third refused
    slow  <= 1'b0;
    stall <= 1'b1;
    @(posedge mclk);
    for (i = 0; i < 3; i++) begin
      u = {32'(8 * i + 8), 32'h0};
      frame(mk(u, s, 1'b1), i < 2);
    end
    repeat (4) @(posedge mclk);
    stall <= 1'b0;
    drain();
    $display("buffer stall done");
    // Mic gain, saturating only for enable value one
    for (i = 0; i < 3; i++) begin
      bus(1'b1, route_pkg::OFF_MIC, {16'h0, 8'(i), 8'h02});
      // Feed lags one sample: the second strobe moves the first into it
      repeat (2) begin
        @(posedge mclk);
        micStb <= 1'b1;
        micRaw <= {32'h0, 32'h20000001};
        @(posedge mclk);
        micStb <= 1'b0;
      end
      #1;
      chk("mic feed", (i == 1) ? 128'h7FFFFFFF : 128'h80000004, {pipeMic.ch1});
    end
    $display("mic gain done");
    // Enables, format lock after start
    bus(1'b1, route_pkg::OFF_ALGO, 32'h2);
    #1;
    chk("enables", 128'h2, {nsEnable, icEnable, aecEnable});
    bus(1'b1, route_pkg::OFF_FORMAT, 32'h5);
    bus(1'b1, route_pkg::OFF_START, 32'h1);
    bus(1'b1, route_pkg::OFF_FORMAT, 32'h3);
    bus(1'b0, route_pkg::OFF_FORMAT, 32'h0);
    chk("format lock", 128'h5, 128'(rd));
    chk("format pins", 128'h5, 128'(formatCfg));
    bus(1'b0, route_pkg::OFF_STATUS, 32'h0);
    chk("started", 128'h1, 128'(rd[0]));
    chk("estimator run", 128'h1, 128'(delayEstRun));
    estDone <= 1'b1;
    bus(1'b0, route_pkg::OFF_STATUS, 32'h0);
    chk("estimate done", 128'h3, 128'(rd[1:0]));
    $display("control done");
    // Second reset restores defaults
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    bus(1'b0, 8'h00, 32'h0);
    chk("map after reset", 128'(route_pkg::RST_SRC_USB0), 128'(rd));
    bus(1'b0, route_pkg::OFF_FORMAT, 32'h0);
    chk("format after reset", 128'(route_pkg::RST_FORMAT), 128'(rd));
    $display("second reset done");
    complete_run();
  end
endmodule
